// File: verilog/sqer_pkg.sv
// Package with register map, codes and carrier structs for sequence error recovery
package sqer_pkg;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_SEQ_LIM   = 8'h04;
  localparam logic [7:0]  REG_LINK_LIM  = 8'h08;
  localparam logic [7:0]  REG_LRP_LIM   = 8'h0C;
  localparam logic [7:0]  REG_STATUS    = 8'h10;
  localparam logic [7:0]  REG_LESB_CNT  = 8'h14;
  localparam logic [7:0]  REG_CRED_CNT  = 8'h18;
  localparam int          CTRL_HOLD     = 0;
  localparam int          CTRL_SEQCRED  = 1;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0002;
  localparam logic [31:0] SEQ_LIM_RST   = 32'h0000_2710;
  localparam logic [31:0] LINK_LIM_RST  = 32'h0000_2710;
  localparam logic [31:0] LRP_LIM_RST   = 32'h0000_2710;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  ABORT_CONT    = 2'h0;
  localparam logic [1:0]  ABORT_ABTS    = 2'h1;
  localparam logic [1:0]  ABORT_STOP    = 2'h2;
  localparam int          TMR_SEQ       = 0;
  localparam int          TMR_LINK      = 1;
  localparam int          TMR_LRP       = 2;
  localparam int          TMR_N         = 3;

  typedef enum logic [1:0] {LRP_IDLE, LRP_WAIT_LRR, LRP_WAIT_IDLE} sqer_lrp_t;

  // Per-frame status from the frame processor, valid when frameValid
  typedef struct packed {
    logic        frameValid;
    logic        isInit;
    logic        cls2;
    logic        cls3;
    logic [15:0] seqCnt;
    logic        endSeq;
    logic        invWordIn;
    logic        eofAbort;
    logic        abnTerm;
    logic        badDelim;
    logic        crcErr;
    logic        classUnsup;
    logic        hdrErr;
    logic [7:0]  hdrReason;
    logic        relOffErr;
    logic        noBuffer;
    logic        abtsRx;
    logic        missingFrame;
    logic        ackStop;
    logic        ackAbort;
    logic        ackErr;
    logic        newSeqMatch;
    logic        stopReq;
  } sqer_evt_t;

  // Sequence and link context levels and pulses
  typedef struct packed {
    logic invWordOut;
    logic syncLoss;
    logic syncLossTmo;
    logic seqActive;
    logic lastSent;
    logic lastSeqFlag;
    logic initXfer;
    logic bbCreditZero;
    logic rRdyRx;
    logic lrSent;
    logic lrrRx;
    logic lrrSent;
    logic idleRx;
  } sqer_ctx_t;

  // Recovery actions, one-cycle pulses except the levels noted in the top
  typedef struct packed {
    logic       discard;
    logic       lesbUpdate;
    logic       reject;
    logic       sendPrjt;
    logic [7:0] rejReason;
    logic       sendRrdy;
    logic       busy;
    logic       linkFail;
    logic       linkReset;
    logic       abts;
    logic       xferInit;
    logic       retryOk;
    logic       abnTerm;
    logic       abtsResp;
    logic       policyErr;
    logic       sendEos;
    logic       recRequest;
    logic       seqDone;
    logic       creditSeq;
    logic       creditAck;
    logic       suppressErr;
    logic       holdInit;
    logic [1:0] abortCode;
  } sqer_act_t;
endpackage

// File: verilog/sqer_timer.sv
// Loadable timeout counter with a one-shot expiry pulse
`timescale 1ns/100ps
module sqer_timer (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic [31:0] limit,
  output logic             expire
);
  logic [31:0] count_q;
  logic        fired_q;
  logic        expire_q;
  wire  [31:0] countInc = count_q + 32'h0000_0001;
  wire         hit      = run && !restart && !fired_q && (countInc >= limit);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q  <= 32'h0000_0000;
      fired_q  <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      expire_q <= hit;
      if (!run || restart) begin
        count_q <= 32'h0000_0000;
        fired_q <= 1'b0;
      end else if (!fired_q) begin
        count_q <= countInc;
        fired_q <= hit;
      end
    end
  end
  assign expire = expire_q;

  a_timer_fires_once: assert property (@(posedge core_clk) disable iff (!arst_n)
    expire |=> !expire) else $error("timer expiry lasted more than one cycle");
endmodule

// File: verilog/sqer_top.sv
// Sequence error recovery action selector with AXI4-Lite register slave
`timescale 1ns/100ps
module sqer_top #(
  parameter logic [31:0] SEQ_TOV_CYC  = sqer_pkg::SEQ_LIM_RST,
  parameter logic [31:0] LINK_TOV_CYC = sqer_pkg::LINK_LIM_RST,
  parameter logic [31:0] LRP_TOV_CYC  = sqer_pkg::LRP_LIM_RST
) (
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  input  wire logic                        losSignalPin,
  input  wire sqer_pkg::sqer_evt_t         evt,
  input  wire sqer_pkg::sqer_ctx_t         ctx,
  output sqer_pkg::sqer_act_t              act,
  input  wire logic [sqer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [sqer_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import sqer_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ---------------- Register slave ----------------
  logic [31:0]       ctrl_q, seqLim_q, linkLim_q, lrpLim_q, lesbCnt_q, credCnt_q;
  logic              awReady_q, wReady_q, awHeld_q, wHeld_q, bValid_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic [1:0]        bResp_q;
  logic              arReady_q, rValid_q;
  logic [31:0]       rData_q;
  logic [1:0]        rResp_q;

  wire awTake   = s_axi_awvalid && awReady_q;
  wire wTake    = s_axi_wvalid && wReady_q;
  wire awHeld_d = awHeld_q || awTake;
  wire wHeld_d  = wHeld_q || wTake;
  wire doWrite  = awHeld_q && wHeld_q && !bValid_q;
  wire bDone    = bValid_q && s_axi_bready;
  wire [31:0] wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire wrCtrl   = doWrite && (awAddr_q == REG_CTRL);
  wire wrSeq    = doWrite && (awAddr_q == REG_SEQ_LIM);
  wire wrLink   = doWrite && (awAddr_q == REG_LINK_LIM);
  wire wrLrp    = doWrite && (awAddr_q == REG_LRP_LIM);
  wire wrLesb   = doWrite && (awAddr_q == REG_LESB_CNT);
  wire wrCred   = doWrite && (awAddr_q == REG_CRED_CNT);
  wire wrHit    = wrCtrl || wrSeq || wrLink || wrLrp || wrLesb || wrCred ||
                  (awAddr_q == REG_STATUS);
  wire arTake   = s_axi_arvalid && arReady_q;

  // Writes to the counters clear them; an event in the same cycle wins and the clear is lost
  logic        stopActive_q, waitEot_q, stopSeen_q;
  logic [15:0] stopCnt_q;
  sqer_lrp_t   lrp_q;
  wire [31:0]  statusWord = {stopCnt_q, 10'h000, lrp_q, 1'b0, stopSeen_q, waitEot_q,
                             stopActive_q};
  logic [31:0] rdMux;
  logic        rdHit;
  always_comb begin
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      REG_CTRL:     rdMux = ctrl_q;
      REG_SEQ_LIM:  rdMux = seqLim_q;
      REG_LINK_LIM: rdMux = linkLim_q;
      REG_LRP_LIM:  rdMux = lrpLim_q;
      REG_STATUS:   rdMux = statusWord;
      REG_LESB_CNT: rdMux = lesbCnt_q;
      REG_CRED_CNT: rdMux = credCnt_q;
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      awReady_q <= 1'b0;
      wReady_q  <= 1'b0;
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awAddr_q  <= '0;
      wData_q   <= 32'h0000_0000;
      wStrb_q   <= 4'h0;
      bValid_q  <= 1'b0;
      bResp_q   <= RESP_OKAY;
    end else begin
      if (awTake) begin
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      awHeld_q  <= awHeld_d && !bDone;
      wHeld_q   <= wHeld_d && !bDone;
      awReady_q <= !awHeld_d || bDone;
      wReady_q  <= !wHeld_d || bDone;
      if (doWrite) begin
        bValid_q <= 1'b1;
        bResp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bDone) begin
        bValid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      arReady_q <= 1'b0;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0000_0000;
      rResp_q   <= RESP_OKAY;
    end else begin
      if (arTake) begin
        rValid_q <= 1'b1;
        rData_q  <= rdMux;
        rResp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid_q && s_axi_rready) begin
        rValid_q <= 1'b0;
      end
      arReady_q <= !(arTake || (rValid_q && !s_axi_rready));
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q    <= CTRL_RST;
      seqLim_q  <= SEQ_TOV_CYC;
      linkLim_q <= LINK_TOV_CYC;
      lrpLim_q  <= LRP_TOV_CYC;
    end else begin
      if (wrCtrl) ctrl_q <= (ctrl_q & ~wMask) | (wData_q & wMask);
      if (wrSeq) seqLim_q <= (seqLim_q & ~wMask) | (wData_q & wMask);
      if (wrLink) linkLim_q <= (linkLim_q & ~wMask) | (wData_q & wMask);
      if (wrLrp) lrpLim_q <= (lrpLim_q & ~wMask) | (wData_q & wMask);
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready  = wReady_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  // ---------------- Loss of signal pin ----------------
  logic losMeta_q, los_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      losMeta_q <= 1'b0;
      los_q     <= 1'b0;
    end else begin
      losMeta_q <= losSignalPin;
      los_q     <= losMeta_q;
    end
  end

  // ---------------- Timers ----------------
  logic [TMR_N-1:0] tmrRun, tmrRestart, tmrExp;
  wire  [31:0]      tmrLim [TMR_N];
  assign tmrLim[TMR_SEQ]  = seqLim_q;
  assign tmrLim[TMR_LINK] = linkLim_q;
  assign tmrLim[TMR_LRP]  = lrpLim_q;
  // sequence timer keeps running while stopping
  assign tmrRun[TMR_SEQ]      = ctx.seqActive && !(waitEot_q && evt.frameValid && evt.newSeqMatch);
  assign tmrRestart[TMR_SEQ]  = evt.frameValid;
  // timed only while no buffer Credit
  assign tmrRun[TMR_LINK]     = ctx.bbCreditZero;
  assign tmrRestart[TMR_LINK] = ctx.rRdyRx;
  assign tmrRun[TMR_LRP]      = (lrp_q != LRP_IDLE);
  assign tmrRestart[TMR_LRP]  = ctx.lrSent || ctx.lrrSent;

  genvar gi;
  generate
    for (gi = 0; gi < TMR_N; gi++) begin : g_tmr
      sqer_timer u_tmr (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .run      (tmrRun[gi]),
        .restart  (tmrRestart[gi]),
        .limit    (tmrLim[gi]),
        .expire   (tmrExp[gi])
      );
    end
  endgenerate

  // Link reset protocol waits; a fresh LR or LRR restarts the wait
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrp_q <= LRP_IDLE;
    end else if (ctx.lrSent) begin
      lrp_q <= LRP_WAIT_LRR;
    end else if (ctx.lrrSent) begin
      lrp_q <= LRP_WAIT_IDLE;
    end else begin
      unique case (lrp_q)
        LRP_IDLE:      lrp_q <= LRP_IDLE;
        LRP_WAIT_LRR:  lrp_q <= (ctx.lrrRx || tmrExp[TMR_LRP]) ? LRP_IDLE : LRP_WAIT_LRR;
        LRP_WAIT_IDLE: lrp_q <= (ctx.idleRx || tmrExp[TMR_LRP]) ? LRP_IDLE : LRP_WAIT_IDLE;
        default:       lrp_q <= LRP_IDLE;
      endcase
    end
  end

  // ---------------- Action selection ----------------
  wire fv      = evt.frameValid;
  wire isRecp  = !evt.isInit;
  wire seqExp  = tmrExp[TMR_SEQ];
  wire isRecpCtx;
  assign isRecpCtx = !ctx.initXfer && !ctx.lastSent && !waitEot_q && !evt.isInit;
  // abort EOF and delimiter faults always dropped
  wire delimDrop = fv && (evt.eofAbort || evt.abnTerm || evt.badDelim || evt.crcErr);
  // invalid word inside a frame drops it
  wire wordDrop  = fv && evt.invWordIn;
  // header faults; offset fault only as recipient
  wire hdrRej    = fv && !delimDrop && !wordDrop &&
                   (evt.classUnsup || evt.hdrErr || (evt.relOffErr && isRecp));
  wire noBuf     = fv && isRecp && evt.noBuffer && !hdrRej && !delimDrop && !wordDrop;
  wire rxAbtsR   = fv && isRecp && evt.abtsRx;
  wire rxAbtsI   = fv && evt.isInit && evt.abtsRx;
  wire missR     = fv && isRecp && evt.missingFrame;
  wire missI     = fv && evt.isInit && evt.missingFrame;
  // ACK errors count only in Class 2
  wire ackErrI   = fv && evt.isInit && evt.cls2 && evt.ackErr;
  wire ackAbtsI  = fv && evt.isInit && evt.ackAbort;
  wire initAbort = rxAbtsI || missI || ackErrI || ackAbtsI || (seqExp && !isRecpCtx);
  wire recpTerm  = seqExp && isRecpCtx;
  // buffer full or upper-layer request starts the stop
  wire stopStart = fv && isRecp && !stopActive_q && (evt.stopReq || evt.noBuffer);
  wire aboveStop = fv && stopActive_q && (evt.seqCnt > stopCnt_q);
  wire eotMatch  = waitEot_q && fv && evt.newSeqMatch;
  wire firstStop = fv && evt.isInit && evt.ackStop && !stopSeen_q;

  logic [1:0] abortCode;
  assign abortCode = (stopActive_q || stopStart) ? ABORT_STOP :
                     missR ? ABORT_ABTS : ABORT_CONT;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stopActive_q <= 1'b0;
      stopCnt_q    <= 16'h0000;
      waitEot_q    <= 1'b0;
      stopSeen_q   <= 1'b0;
    end else begin
      // stop holds until the sequence ends or is terminated
      if (stopStart) begin
        stopActive_q <= 1'b1;
        stopCnt_q    <= evt.seqCnt;
      end else if ((fv && evt.endSeq) || recpTerm || rxAbtsR) begin
        stopActive_q <= 1'b0;
      end
      // waiting for the terminating EOF after initiative passed
      if (eotMatch || !ctx.seqActive) begin
        waitEot_q <= 1'b0;
      end else if (ctx.lastSent && ctx.initXfer) begin
        waitEot_q <= 1'b1;
      end
      if (firstStop) begin
        stopSeen_q <= 1'b1;
      end else if (!ctx.seqActive) begin
        stopSeen_q <= 1'b0;
      end
    end
  end

  sqer_act_t act_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_q <= '0;
    end else begin
      // discard on delimiter and CRC faults, class 3 shortage
      act_q.discard     <= delimDrop || wordDrop || hdrRej || (noBuf && !evt.cls2);
      act_q.lesbUpdate  <= wordDrop || ctx.invWordOut || ctx.syncLoss;
      // reject with R_RDY, sendPrjt only in Class 2; reason given in every class
      act_q.reject      <= hdrRej;
      act_q.sendRrdy    <= hdrRej;
      act_q.sendPrjt    <= hdrRej && evt.cls2;
      act_q.rejReason   <= hdrRej ? evt.hdrReason : 8'h00;
      act_q.busy        <= noBuf && evt.cls2;
      // link failure; link reset protocol timeout
      act_q.linkFail    <= los_q || ctx.syncLossTmo || tmrExp[TMR_LRP];
      act_q.linkReset   <= tmrExp[TMR_LINK];
      act_q.abts        <= initAbort && !eotMatch;
      act_q.xferInit    <= initAbort && !eotMatch;
      act_q.retryOk     <= (rxAbtsI || seqExp) && !isRecpCtx;
      act_q.abnTerm     <= recpTerm;
      act_q.abtsResp    <= rxAbtsR;
      // missing frame gives error policy handling
      act_q.policyErr   <= missR || missI;
      // one End_Sequence frame on the first stop ACK
      act_q.sendEos     <= firstStop && !ctx.lastSent;
      act_q.recRequest  <= seqExp && !isRecpCtx && ctx.lastSent && ctx.lastSeqFlag;
      act_q.seqDone     <= eotMatch;
      // per-sequence Credit back on abort or termination
      act_q.creditSeq   <= ctrl_q[CTRL_SEQCRED] && (recpTerm || initAbort || rxAbtsR);
      // ACK Credit reclaim in Class 2 only
      act_q.creditAck   <= initAbort && evt.cls2;
      // errors above the stop point are not reported
      act_q.suppressErr <= aboveStop;
      // initiative after stop follows upper-layer setting
      act_q.holdInit    <= ctrl_q[CTRL_HOLD];
      act_q.abortCode   <= abortCode;
    end
  end
  assign act = act_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lesbCnt_q <= 32'h0000_0000;
      credCnt_q <= 32'h0000_0000;
    end else begin
      if (act_q.lesbUpdate) lesbCnt_q <= lesbCnt_q + 32'h0000_0001;
      else if (wrLesb) lesbCnt_q <= 32'h0000_0000;
      if (act_q.creditSeq || act_q.creditAck) credCnt_q <= credCnt_q + 32'h0000_0001;
      else if (wrCred) credCnt_q <= 32'h0000_0000;
    end
  end

  // ---------------- Checks ----------------
  sequence s_stop_begin;
    stopStart;
  endsequence
  sequence s_stop_marked;
    act.abortCode == ABORT_STOP;
  endsequence

  a_stop_ack_code: assert property (s_stop_begin |=> s_stop_marked)
    else $error("stop code missing in ACK");
  a_stop_holds: assert property (stopActive_q && !stopStart |=> s_stop_marked)
    else $error("stop code dropped while stopping");
  a_eos_once: assert property (firstStop && !ctx.lastSent |=> act.sendEos ##1 !act.sendEos)
    else $error("End_Sequence frame not sent once");
  a_suppress_above: assert property (aboveStop |=> act.suppressErr)
    else $error("error report not suppressed above stop");
  a_link_reset: assert property (tmrExp[TMR_LINK] |=> act.linkReset)
    else $error("link timeout did not start link reset");
  a_lrp_failure: assert property (lrp_q == LRP_WAIT_LRR && tmrExp[TMR_LRP] && !ctx.lrSent
    && !ctx.lrrSent |=> act.linkFail && lrp_q == LRP_IDLE)
    else $error("missing LRR did not start link failure");
  a_reject_rrdy: assert property (act.reject |-> act.sendRrdy && act.discard)
    else $error("reject without R_RDY and discard");
  a_busy_class: assert property (noBuf && evt.cls2 |=> act.busy && !act.discard)
    else $error("class 2 shortage not answered busy");
  a_recp_term: assert property (recpTerm |=> act.abnTerm && !act.abts)
    else $error("recipient timeout not terminated");
  a_eot_done: assert property (eotMatch |=> act.seqDone && !act.abts)
    else $error("matching new sequence did not end wait");
endmodule

// File: dv/sqer_peer.sv
// Peer port model that hands one frame status to the block per call
`timescale 1ns/100ps
module sqer_peer (
  input  wire logic           core_clk,
  output sqer_pkg::sqer_evt_t evt
);
  import sqer_pkg::*;
  initial evt = '0;
  // abort flags passed whole
  // One-cycle strobe, so the status never lingers into a second frame
  task automatic send(input sqer_evt_t e);
    e.frameValid = 1'b1;
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
    #1;
  endtask
endmodule

// File: dv/test_sqer_top.sv
// Self-checking bench for the sequence error recovery block
`timescale 1ns/100ps
module test_sqer_top;
  import sqer_pkg::*;
  logic        core_clk, arst_n, losSignalPin;
  sqer_evt_t   evt, e;
  sqer_ctx_t   ctx;
  sqer_act_t   act;
  logic [7:0]  awAddr, arAddr;
  logic [31:0] wData, rData, rd;
  logic [3:0]  wStrb;
  logic        awValid, awReady, wValid, wReady, bValid, bReady;
  logic        arValid, arReady, rValid, rReady;
  logic [1:0]  bResp, rResp, rs;
  int          err_count, cmp_count, n;
  sqer_top #(.SEQ_TOV_CYC(32'h0000_0008), .LINK_TOV_CYC(32'h0000_0008),
    .LRP_TOV_CYC(32'h0000_0008)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .losSignalPin(losSignalPin), .evt(evt), .ctx(ctx), .act(act),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  sqer_peer u_peer (.core_clk(core_clk), .evt(evt));
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (x !== g) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, x, g);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (!(bValid && bReady));
    rs = bResp;
    bReady <= 1'b0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arValid && arReady) arValid <= 1'b0;
    end while (!(rValid && rReady));
    rd = rData;
    rs = rResp;
    rReady <= 1'b0;
  endtask
  // Bounded wait of up to 30 cycles for one action pulse; n holds the cycles spent before the pulse cycle
  task waitp(input int s);
    for (n = 0; n < 30; n++) begin
      @(posedge core_clk);
      #1;
      if ((s == 0 && act.linkReset) || (s == 1 && act.abnTerm) || (s == 2 && act.linkFail) ||
          (s == 3 && act.abts)) break;
    end
  endtask
  task regs;
    axr(REG_CTRL);
    chk("ctrl", CTRL_RST, rd);
    axr(REG_SEQ_LIM);
    chk("seqLim", 32'h0000_0008, rd);
    axr(8'h40);
    chk("unmapped", 32'(RESP_SLVERR), 32'(rs));
    axw(8'h40, 32'h0000_0001);
    chk("unmappedW", 32'(RESP_SLVERR), 32'(rs));
    axw(REG_CTRL, 32'h0000_0003);
    chk("ctrlResp", 32'(RESP_OKAY), 32'(rs));
    axr(REG_CTRL);
    chk("ctrlBack", 32'h0000_0003, rd);
    repeat (2) @(posedge core_clk);
    chk("holdInit", 32'h0000_0001, 32'(act.holdInit));
  endtask
  task frames;
    e = '0;
    e.cls2 = 1'b1;
    e.hdrErr = 1'b1;
    e.hdrReason = 8'h5A;
    u_peer.send(e);
    chk("reject", 32'h0000_001E, 32'({act.reject, act.sendRrdy, act.sendPrjt, act.discard, act.busy}));
    chk("reason", 32'h0000_005A, 32'(act.rejReason));
    e.hdrErr = 1'b0;
    e.noBuffer = 1'b1;
    u_peer.send(e);
    chk("busy2", 32'h0000_0001, 32'(act.busy));
    chk("bufStop", 32'(ABORT_STOP), 32'(act.abortCode));
    e.cls2 = 1'b0;
    e.cls3 = 1'b1;
    u_peer.send(e);
    chk("drop3", 32'h0000_0001, 32'({act.busy, act.discard}));
    e = '0;
    e.crcErr = 1'b1;
    u_peer.send(e);
    chk("crc", 32'h0000_0001, 32'({act.reject, act.discard}));
    e.crcErr = 1'b0;
    e.invWordIn = 1'b1;
    u_peer.send(e);
    chk("word", 32'h0000_0003, 32'({act.reject, act.discard, act.lesbUpdate}));
    e.invWordIn = 1'b0;
    e.isInit = 1'b1;
    e.relOffErr = 1'b1;
    u_peer.send(e);
    chk("offInit", 32'h0000_0000, 32'({act.reject, act.discard}));
    e.isInit = 1'b0;
    u_peer.send(e);
    chk("offRecp", 32'h0000_0003, 32'({act.reject, act.discard}));
  endtask
  task stop;
    // End the stop left over from the buffer shortage first
    e = '0;
    e.endSeq = 1'b1;
    u_peer.send(e);
    e.endSeq = 1'b0;
    e.stopReq = 1'b1;
    e.seqCnt = 16'h0003;
    u_peer.send(e);
    chk("stopCode", 32'(ABORT_STOP), 32'(act.abortCode));
    e.stopReq = 1'b0;
    e.seqCnt = 16'h0005;
    u_peer.send(e);
    chk("laterCode", 32'(ABORT_STOP), 32'(act.abortCode));
    chk("suppress", 32'h0000_0001, 32'(act.suppressErr));
    e.seqCnt = 16'h0002;
    u_peer.send(e);
    chk("noSuppress", 32'h0000_0000, 32'(act.suppressErr));
    e.endSeq = 1'b1;
    u_peer.send(e);
    e.endSeq = 1'b0;
    e.missingFrame = 1'b1;
    u_peer.send(e);
    chk("missCode", 32'(ABORT_ABTS), 32'({act.abortCode}));
    chk("missPolicy", 32'h0000_0001, 32'(act.policyErr));
  endtask
  task timers;
    @(posedge core_clk);
    ctx.bbCreditZero <= 1'b1;
    waitp(0);
    @(posedge core_clk);
    ctx.bbCreditZero <= 1'b0;
    chk("linkReset", 32'h0000_0001, 32'(n >= 7 && n < 30));
    ctx.seqActive <= 1'b1;
    waitp(1);
    @(posedge core_clk);
    ctx.seqActive <= 1'b0;
    chk("abnTerm", 32'h0000_0001, 32'(n >= 7 && n < 30));
    losSignalPin <= 1'b1;
    waitp(2);
    @(posedge core_clk);
    losSignalPin <= 1'b0;
    chk("losFail", 32'h0000_0001, 32'(n < 8));
    // Let the synchronised loss level drain before the next failure cause
    repeat (4) @(posedge core_clk);
    ctx.lrSent <= 1'b1;
    @(posedge core_clk);
    ctx.lrSent <= 1'b0;
    waitp(2);
    chk("lrrFail", 32'h0000_0001, 32'(n >= 6 && n < 30));
    @(posedge core_clk);
    ctx.lrrSent <= 1'b1;
    @(posedge core_clk);
    ctx.lrrSent <= 1'b0;
    waitp(2);
    chk("idleFail", 32'h0000_0001, 32'(n >= 6 && n < 30));
  endtask
  task initr;
    @(posedge core_clk);
    ctx.seqActive <= 1'b1;
    ctx.lastSent <= 1'b1;
    ctx.lastSeqFlag <= 1'b1;
    waitp(3);
    chk("seqTmo", 32'h0000_000E, 32'({act.abts, act.xferInit, act.retryOk, act.abnTerm}));
    chk("recReq", 32'h0000_0001, 32'(act.recRequest));
    chk("seqCred", 32'h0000_0001, 32'(act.creditSeq));
    @(posedge core_clk);
    ctx.initXfer <= 1'b1;
    e = '0;
    e.newSeqMatch = 1'b1;
    u_peer.send(e);
    chk("eotDone", 32'h0000_0002, 32'({act.seqDone, act.abts}));
    @(posedge core_clk);
    ctx.lastSent <= 1'b0;
    ctx.initXfer <= 1'b0;
    e = '0;
    e.isInit = 1'b1;
    e.ackStop = 1'b1;
    u_peer.send(e);
    chk("eosFirst", 32'h0000_0001, 32'(act.sendEos));
    u_peer.send(e);
    chk("eosAgain", 32'h0000_0000, 32'(act.sendEos));
    e.ackStop = 1'b0;
    e.ackAbort = 1'b1;
    e.cls2 = 1'b1;
    u_peer.send(e);
    chk("abortAck", 32'h0000_0006, 32'({act.abts, act.xferInit, act.retryOk}));
    chk("ackCred", 32'h0000_0001, 32'(act.creditAck));
    e.ackAbort = 1'b0;
    e.ackErr = 1'b1;
    e.cls2 = 1'b0;
    u_peer.send(e);
    chk("ackErr3", 32'h0000_0000, 32'(act.abts));
    e.ackErr = 1'b0;
    e.missingFrame = 1'b1;
    u_peer.send(e);
    chk("missInit", 32'h0000_0003, 32'({act.policyErr, act.abts}));
    @(posedge core_clk);
    ctx <= '0;
  endtask
  task summarize;
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    err_count++;
    summarize();
  end
  initial begin
    {arst_n, losSignalPin, ctx, awAddr, arAddr, wData} = '0;
    {awValid, wValid, bReady, arValid, rReady} = '0;
    wStrb = 4'hF;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    regs();
    frames();
    stop();
    timers();
    initr();
    summarize();
  end
endmodule
